// ---- i2rb_pkg.sv ----
/*
 Constants and types for the two-wire register bridge.
 Assumes a single 50 MHz core clock and an active-low async reset.
*/
// What this block does
// - slave only, two-wire bus, fast mode
// - fetch on acknowledge, increment, shift eight bits
// - stale read address repeats first byte only
// - store each data byte, then increment address
// - no hs-mode, 10-bit, general call, ID
// - never stretch the clock line
// - 7-bit address chosen by pins, three values
// - every byte shifted most significant bit first
// - repeated START accepted as STOP plus START
// - reset pin loads defaults asynchronously everywhere except the FIFO storage
// - soft reset spares interface, bit, latched straps
// - register space 000h to 1FFh, bit 7 MSB
// - writes to read-only fields are ignored
// - latched bits write-one-clear, real-time bits live
// - every configuration field but master config bit 7 returns to default
// - command 0x02 writes, 0x03 reads
// - master config bit 7 holds device in reset
package i2rb_pkg;
   localparam int unsigned CLK_MHZ       = 50;
   localparam int unsigned READY_WAIT_US = 100;
   localparam int unsigned READY_CYCLES  = READY_WAIT_US * CLK_MHZ;
   localparam int unsigned REG_COUNT     = 512;
   localparam int unsigned FIFO_DEPTH    = 32;
   localparam int unsigned PIN_W         = 13;
   localparam logic [12:0] PIN_RESET     = 13'h1800;
   localparam logic [7:0]  CMD_WR        = 8'h02;
   localparam logic [7:0]  CMD_RD        = 8'h03;
   localparam logic [8:0]  MCR_ADDR      = 9'h009;
   localparam logic [7:0]  MCR_RESET     = 8'h01;
   localparam logic [7:0]  MCR_KEEP      = 8'h80;
   localparam int unsigned MCR_RST_BIT   = 7;
   localparam logic [8:0]  STRAP_ADDR    = 9'h040;
   localparam logic [8:0]  GSTAT_ADDR    = 9'h043;
   localparam logic [8:0]  RT_ADDR       = 9'h048;
   localparam logic [8:0]  LATCH_ADDR    = 9'h049;
   localparam logic [2:0]  STRAP_TAKE    = 3'h6;
   localparam logic [2:0]  STRAP_WAIT    = 3'h7;
   // slave addresses: arbitrary values
   localparam logic [6:0]  SLAVE_ADDR0   = 7'h50;
   localparam logic [6:0]  SLAVE_ADDR1   = 7'h51;
   localparam logic [6:0]  SLAVE_ADDR2   = 7'h52;

   typedef struct packed {
      logic [8:0] addr;
      logic [7:0] data;
   } i2rb_wr_req_t;

   typedef enum logic [2:0] {
      ST_IDLE     = 3'h0,
      ST_ADDR     = 3'h1,
      ST_ADDR_ACK = 3'h3,
      ST_WR_BYTE  = 3'h2,
      ST_WR_ACK   = 3'h6,
      ST_RD_BYTE  = 3'h7,
      ST_RD_ACK   = 3'h5
   } i2rb_state_t;
endpackage : i2rb_pkg

// ---- i2rb_fifo.sv ----
/*
 Flip-flop FIFO with valid/ready on both sides.
 Assumes one clock; depth is a power of two.
*/
`timescale 1ns/10ps
module i2rb_fifo #(
   parameter int unsigned WIDTH = 17,
   parameter int unsigned DEPTH = 32
) (
   input  wire logic             core_clk_in,
   input  wire logic             arst_n_in,
   input  wire logic             in_valid_in,
   output logic                  in_ready_out,
   input  wire logic [WIDTH-1:0] in_data_in,
   output logic                  out_valid_out,
   input  wire logic             out_ready_in,
   output logic [WIDTH-1:0]      out_data_out
);
   localparam int unsigned AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_reg [DEPTH];
   logic [AW:0]      wr_ptr_reg;
   logic [AW:0]      rd_ptr_reg;
   wire logic        full;
   wire logic        empty;
   wire logic        push;
   wire logic        pop;

   assign full  = (wr_ptr_reg[AW] != rd_ptr_reg[AW]) &&
                  (wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]);
   assign empty = wr_ptr_reg == rd_ptr_reg;
   assign push  = in_valid_in && !full;
   assign pop   = out_ready_in && !empty;
   assign in_ready_out  = !full;
   assign out_valid_out = !empty;
   assign out_data_out  = mem_reg[rd_ptr_reg[AW-1:0]];

   always_ff @(posedge core_clk_in) begin
      if (push) begin
         mem_reg[wr_ptr_reg[AW-1:0]] <= in_data_in;
      end
   end

   always_ff @(posedge core_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
      end else begin
         wr_ptr_reg <= wr_ptr_reg + (AW+1)'(push);
         rd_ptr_reg <= rd_ptr_reg + (AW+1)'(pop);
      end
   end
endmodule : i2rb_fifo

// ---- i2rb_bridge.sv ----
/*
 Two-wire slave that bridges bus transfers to a 512-byte register space,
 with soft reset, strap capture, ready timer and status bits.
 Assumes open-drain SDA resolved outside; SCL is only ever an input.
*/
`timescale 1ns/10ps
module i2rb_bridge #(
   parameter int unsigned READY_CYCLES = i2rb_pkg::READY_CYCLES
) (
   input  wire logic       core_clk_in,
   input  wire logic       arst_n_in,
   input  wire logic       scl_in,
   input  wire logic       sda_in,
   input  wire logic [1:0] addr_sel_in,
   input  wire logic       iface_select_pin_one_in,
   input  wire logic [7:0] status_level_in,
   output logic            sda_out,
   output logic            sda_oe_out,
   output logic            ready_out,
   output logic            soft_rst_out,
   output logic [1:0]      xab_out
);
   localparam int unsigned N = i2rb_pkg::REG_COUNT;

   // pin synchronisers and filtered levels
   logic [i2rb_pkg::PIN_W-1:0] pin_s1_reg;
   logic [i2rb_pkg::PIN_W-1:0] pin_s2_reg;
   logic [i2rb_pkg::PIN_W-1:0] pin_s3_reg;
   logic [i2rb_pkg::PIN_W-1:0] pin_f_reg;
   logic [i2rb_pkg::PIN_W-1:0] pin_p_reg;
   wire logic [i2rb_pkg::PIN_W-1:0] pin_raw;
   wire logic [i2rb_pkg::PIN_W-1:0] pin_f_next;
   wire logic scl_f, sda_f, scl_rise, scl_fall, start_det, stop_det;

   // protocol state
   i2rb_pkg::i2rb_state_t state_reg, state_next;
   logic [2:0]  bit_reg, bit_next;
   logic [7:0]  shift_reg, shift_next;
   logic        oe_reg, oe_next;
   logic        got_reg, got_next;
   logic [1:0]  bcnt_reg, bcnt_next;
   logic [7:0]  cmd_reg, cmd_next;
   logic [7:0]  hi_reg, hi_next;
   logic [15:0] rd_addr_reg, rd_addr_next;
   logic [15:0] wr_addr_reg, wr_addr_next;
   logic [7:0]  rd_data_reg, rd_data_next;
   logic        rd_mode_reg, rd_mode_next;
   logic        inc_reg, inc_next;
   logic        pend_reg, pend_next;

   // register space and housekeeping
   wire logic [N-1:0][7:0] store_q;
   logic [2:0]  strap_reg;
   logic [2:0]  strap_wait_reg;
   logic [7:0]  latch_reg;
   logic [15:0] ready_cnt_reg;
   logic        ready_reg;
   logic        soft_rst_reg;
   logic [1:0]  xab_reg;
   logic        sda_out_reg;
   wire logic [6:0] my_addr;
   wire logic addr_hit, wr_ack, wr_push, fetch_now, byte_end;
   wire logic mcr_rst, rd_in_range, wr_in_range, ro_addr, wr_ok;
   wire logic [7:0] read_val;
   wire logic [7:0] latch_clr;
   wire logic [15:0] ready_limit;
   wire logic fifo_in_ready, fifo_out_valid, fifo_out_ready, wr_fire;
   i2rb_pkg::i2rb_wr_req_t push_req, wr_req;

   assign pin_raw = {scl_in, sda_in, iface_select_pin_one_in,
                     addr_sel_in, status_level_in};
   // a level counts once the second and third stages agree
   assign pin_f_next = (pin_s2_reg & pin_s3_reg) |
                       (pin_f_reg & (pin_s2_reg ^ pin_s3_reg));
   assign scl_f     = pin_f_reg[12];
   assign sda_f     = pin_f_reg[11];
   assign scl_rise  = scl_f && !pin_p_reg[12];
   assign scl_fall  = !scl_f && pin_p_reg[12];
   assign start_det = scl_f && pin_p_reg[12] && pin_p_reg[11] && !sda_f;
   assign stop_det  = scl_f && pin_p_reg[12] && !pin_p_reg[11] && sda_f;
   assign byte_end  = scl_fall && got_reg && !start_det && !stop_det;

   assign my_addr = (strap_reg[1:0] == 2'h0) ? i2rb_pkg::SLAVE_ADDR0 :
                    (strap_reg[1:0] == 2'h1) ? i2rb_pkg::SLAVE_ADDR1 :
                    i2rb_pkg::SLAVE_ADDR2;
   // 7-bit compare only; general call and 10-bit prefixes never match
   assign addr_hit = shift_reg[7:1] == my_addr;
   assign wr_in_range = wr_addr_reg[15:9] == 7'h00;
   assign rd_in_range = rd_addr_reg[15:9] == 7'h00;
   // a full FIFO makes the data byte NACK: no clock stretching
   assign wr_ack  = (bcnt_reg != 2'h3) || (cmd_reg != i2rb_pkg::CMD_WR) ||
                    fifo_in_ready;
   assign wr_push = byte_end && (state_reg == i2rb_pkg::ST_WR_BYTE) &&
                    (bcnt_reg == 2'h3) && (cmd_reg == i2rb_pkg::CMD_WR) &&
                    fifo_in_ready && wr_in_range;
   assign fetch_now = scl_rise && !start_det && !stop_det &&
      (((state_reg == i2rb_pkg::ST_ADDR_ACK) && rd_mode_reg) ||
       ((state_reg == i2rb_pkg::ST_RD_ACK) && !sda_f));
   assign push_req = '{addr: wr_addr_reg[8:0], data: shift_reg};

   assign read_val = !rd_in_range ? 8'h00 :
      (rd_addr_reg[8:0] == i2rb_pkg::STRAP_ADDR) ? {5'h00, strap_reg} :
      (rd_addr_reg[8:0] == i2rb_pkg::GSTAT_ADDR) ? {ready_reg, 7'h00} :
      (rd_addr_reg[8:0] == i2rb_pkg::RT_ADDR) ? pin_f_reg[7:0] :
      (rd_addr_reg[8:0] == i2rb_pkg::LATCH_ADDR) ? latch_reg :
      store_q[rd_addr_reg[8:0]];

   always_comb begin
      state_next   = state_reg;
      bit_next     = bit_reg;
      shift_next   = shift_reg;
      oe_next      = oe_reg;
      got_next     = got_reg;
      bcnt_next    = bcnt_reg;
      cmd_next     = cmd_reg;
      hi_next      = hi_reg;
      rd_addr_next = rd_addr_reg;
      wr_addr_next = wr_addr_reg;
      rd_data_next = rd_data_reg;
      rd_mode_next = rd_mode_reg;
      inc_next     = inc_reg;
      pend_next    = pend_reg;
      if (start_det) begin
         state_next   = i2rb_pkg::ST_ADDR;
         bit_next     = 3'h0;
         got_next     = 1'b0;
         oe_next      = 1'b0;
         rd_mode_next = 1'b0;
      end else if (stop_det) begin
         state_next   = i2rb_pkg::ST_IDLE;
         got_next     = 1'b0;
         oe_next      = 1'b0;
         rd_mode_next = 1'b0;
      end else begin
         case (state_reg)
            i2rb_pkg::ST_ADDR, i2rb_pkg::ST_WR_BYTE: begin
               if (scl_rise) begin
                  shift_next = {shift_reg[6:0], sda_f};
                  bit_next   = bit_reg + 3'h1;
                  got_next   = bit_reg == 3'h7;
               end else if (byte_end) begin
                  got_next = 1'b0;
                  if (state_reg == i2rb_pkg::ST_ADDR) begin
                     // any address phase ends a pending read set-up
                     pend_next = 1'b0;
                     if (addr_hit) begin
                        oe_next      = 1'b1;
                        state_next   = i2rb_pkg::ST_ADDR_ACK;
                        rd_mode_next = shift_reg[0];
                        inc_next     = pend_reg;
                        bcnt_next    = 2'h0;
                     end else begin
                        state_next = i2rb_pkg::ST_IDLE;
                     end
                  end else if (wr_ack) begin
                     oe_next    = 1'b1;
                     state_next = i2rb_pkg::ST_WR_ACK;
                     if (bcnt_reg != 2'h3) begin
                        bcnt_next = bcnt_reg + 2'h1;
                     end
                     case (bcnt_reg)
                        2'h0: cmd_next = shift_reg;
                        2'h1: hi_next = shift_reg;
                        2'h2: begin
                           if (cmd_reg == i2rb_pkg::CMD_RD) begin
                              rd_addr_next = {hi_reg, shift_reg};
                              pend_next    = 1'b1;
                           end else if (cmd_reg == i2rb_pkg::CMD_WR) begin
                              wr_addr_next = {hi_reg, shift_reg};
                           end
                        end
                        default: begin
                           if (cmd_reg == i2rb_pkg::CMD_WR) begin
                              wr_addr_next = wr_addr_reg + 16'h0001;
                           end
                        end
                     endcase
                  end else begin
                     state_next = i2rb_pkg::ST_IDLE;
                  end
               end
            end
            i2rb_pkg::ST_ADDR_ACK: begin
               if (scl_fall) begin
                  bit_next = 3'h0;
                  if (rd_mode_reg) begin
                     shift_next = rd_data_reg;
                     oe_next    = !rd_data_reg[7];
                     state_next = i2rb_pkg::ST_RD_BYTE;
                  end else begin
                     oe_next    = 1'b0;
                     state_next = i2rb_pkg::ST_WR_BYTE;
                  end
               end
            end
            i2rb_pkg::ST_WR_ACK: begin
               if (scl_fall) begin
                  oe_next    = 1'b0;
                  bit_next   = 3'h0;
                  state_next = i2rb_pkg::ST_WR_BYTE;
               end
            end
            i2rb_pkg::ST_RD_BYTE: begin
               if (scl_fall) begin
                  if (bit_reg == 3'h7) begin
                     oe_next    = 1'b0;
                     state_next = i2rb_pkg::ST_RD_ACK;
                  end else begin
                     shift_next = {shift_reg[6:0], 1'b0};
                     oe_next    = !shift_reg[6];
                     bit_next   = bit_reg + 3'h1;
                  end
               end
            end
            i2rb_pkg::ST_RD_ACK: begin
               // ack: reuse the ack-fall load path; nack: go quiet
               if (scl_rise) begin
                  state_next = sda_f ? i2rb_pkg::ST_IDLE
                                     : i2rb_pkg::ST_ADDR_ACK;
               end
            end
            default: begin
               state_next = i2rb_pkg::ST_IDLE;
            end
         endcase
         if (fetch_now) begin
            rd_data_next = read_val;
            if (inc_reg) begin
               rd_addr_next = rd_addr_reg + 16'h0001;
            end
         end
      end
   end

   always_ff @(posedge core_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         pin_s1_reg <= i2rb_pkg::PIN_RESET;
         pin_s2_reg <= i2rb_pkg::PIN_RESET;
         pin_s3_reg <= i2rb_pkg::PIN_RESET;
         pin_f_reg  <= i2rb_pkg::PIN_RESET;
         pin_p_reg  <= i2rb_pkg::PIN_RESET;
      end else begin
         pin_s1_reg <= pin_raw;
         pin_s2_reg <= pin_s1_reg;
         pin_s3_reg <= pin_s2_reg;
         pin_f_reg  <= pin_f_next;
         pin_p_reg  <= pin_f_reg;
      end
   end

   // interface logic is untouched by the soft reset
   always_ff @(posedge core_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         state_reg   <= i2rb_pkg::ST_IDLE;
         bit_reg     <= 3'h0;
         shift_reg   <= 8'h00;
         oe_reg      <= 1'b0;
         got_reg     <= 1'b0;
         bcnt_reg    <= 2'h0;
         cmd_reg     <= 8'h00;
         hi_reg      <= 8'h00;
         rd_addr_reg <= 16'h0000;
         wr_addr_reg <= 16'h0000;
         rd_data_reg <= 8'h00;
         rd_mode_reg <= 1'b0;
         inc_reg     <= 1'b0;
         pend_reg    <= 1'b0;
      end else begin
         state_reg   <= state_next;
         bit_reg     <= bit_next;
         shift_reg   <= shift_next;
         oe_reg      <= oe_next;
         got_reg     <= got_next;
         bcnt_reg    <= bcnt_next;
         cmd_reg     <= cmd_next;
         hi_reg      <= hi_next;
         rd_addr_reg <= rd_addr_next;
         wr_addr_reg <= wr_addr_next;
         rd_data_reg <= rd_data_next;
         rd_mode_reg <= rd_mode_next;
         inc_reg     <= inc_next;
         pend_reg    <= pend_next;
      end
   end

   // received writes queue here; drain yields to a read fetch
   assign fifo_out_ready = !fetch_now;
   assign wr_fire = fifo_out_valid && fifo_out_ready;

   i2rb_fifo #(
      .WIDTH ($bits(i2rb_pkg::i2rb_wr_req_t)),
      .DEPTH (i2rb_pkg::FIFO_DEPTH)
   ) u_wr_fifo (
      .core_clk_in   (core_clk_in),
      .arst_n_in     (arst_n_in),
      .in_valid_in   (wr_push),
      .in_ready_out  (fifo_in_ready),
      .in_data_in    (push_req),
      .out_valid_out (fifo_out_valid),
      .out_ready_in  (fifo_out_ready),
      .out_data_out  (wr_req)
   );

   assign mcr_rst = store_q[i2rb_pkg::MCR_ADDR][i2rb_pkg::MCR_RST_BIT];
   assign ro_addr = (wr_req.addr == i2rb_pkg::STRAP_ADDR) ||
                    (wr_req.addr == i2rb_pkg::GSTAT_ADDR) ||
                    (wr_req.addr == i2rb_pkg::RT_ADDR) ||
                    (wr_req.addr == i2rb_pkg::LATCH_ADDR);
   // while held in soft reset only the master config byte takes writes
   assign wr_ok = wr_fire && !ro_addr &&
                  (!mcr_rst || (wr_req.addr == i2rb_pkg::MCR_ADDR));

   for (genvar i = 0; i < N; i++) begin : g_ent
      localparam logic [7:0] DEF  = (i == int'(i2rb_pkg::MCR_ADDR)) ?
                                    i2rb_pkg::MCR_RESET : 8'h00;
      localparam logic [7:0] KEEP = (i == int'(i2rb_pkg::MCR_ADDR)) ?
                                    i2rb_pkg::MCR_KEEP : 8'h00;
      logic [7:0] ent_reg;
      wire logic  hit;
      assign hit = wr_ok && (wr_req.addr == 9'(i));
      always_ff @(posedge core_clk_in or negedge arst_n_in) begin
         if (!arst_n_in) begin
            ent_reg <= DEF;
         end else if (hit) begin
            ent_reg <= wr_req.data;
         end else if (mcr_rst) begin
            ent_reg <= (ent_reg & KEEP) | (DEF & ~KEEP);
         end
      end
      assign store_q[i] = ent_reg;
   end

   assign latch_clr = (wr_fire && (wr_req.addr == i2rb_pkg::LATCH_ADDR)) ?
                      wr_req.data : 8'h00;
   assign ready_limit = 16'(READY_CYCLES);

   always_ff @(posedge core_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         strap_wait_reg <= 3'h0;
         strap_reg      <= 3'h0;
         latch_reg      <= 8'h00;
         ready_cnt_reg  <= 16'h0000;
         ready_reg      <= 1'b0;
         soft_rst_reg   <= 1'b0;
         xab_reg        <= 2'h0;
         sda_out_reg    <= 1'b0;
      end else begin
         // straps caught once after the pin reset, never on soft reset
         if (strap_wait_reg != i2rb_pkg::STRAP_WAIT) begin
            strap_wait_reg <= strap_wait_reg + 3'h1;
         end
         if (strap_wait_reg == i2rb_pkg::STRAP_TAKE) begin
            strap_reg <= pin_f_reg[10:8];
         end
         // set wins over a same-cycle write-one clear
         latch_reg <= mcr_rst ? 8'h00 :
            (latch_reg & ~latch_clr) | (pin_f_reg[7:0] & ~pin_p_reg[7:0]);
         if (mcr_rst) begin
            ready_cnt_reg <= 16'h0000;
         end else if (ready_cnt_reg != ready_limit) begin
            ready_cnt_reg <= ready_cnt_reg + 16'h0001;
         end
         ready_reg    <= !mcr_rst && (ready_cnt_reg == ready_limit);
         soft_rst_reg <= mcr_rst;
         xab_reg      <= store_q[i2rb_pkg::MCR_ADDR][1:0];
         sda_out_reg  <= 1'b0;
      end
   end

   assign sda_out      = sda_out_reg;
   assign sda_oe_out   = oe_reg;
   assign ready_out    = ready_reg;
   assign soft_rst_out = soft_rst_reg;
   assign xab_out      = xab_reg;
endmodule : i2rb_bridge

// ---- i2rb_bridge_assertions.sv ----
/* Port-level checks on the two-wire register bridge.
 Assumes a bind onto every bridge instance, one clock domain. */
`timescale 1ns/10ps
module i2rb_bridge_assertions (
   input wire logic       core_clk_in,
   input wire logic       arst_n_in,
   input wire logic       scl_in,
   input wire logic       sda_out,
   input wire logic       sda_oe_out,
   input wire logic       ready_out,
   input wire logic       soft_rst_out,
   input wire logic [1:0] xab_out
);
   default clocking cb @(posedge core_clk_in); endclocking
   default disable iff (!arst_n_in);
   a_open_drain: assert property (sda_out == 1'b0)
      else $error("data pin driven high");
   a_oe_rise_low: assert property ($rose(sda_oe_out) |-> !scl_in)
      else $error("data pulled low while clock high");
   a_oe_fall_low: assert property ($fell(sda_oe_out) |-> !scl_in)
      else $error("data released while clock high");
   a_reset_quiet: assert property (disable iff (1'b0) !arst_n_in |->
      !sda_oe_out && !ready_out && !soft_rst_out && xab_out == 2'h0)
      else $error("outputs active during reset");
   a_ready_wait: assert property ($rose(arst_n_in) |-> !ready_out [*8])
      else $error("ready too early after reset");
   a_xab_default: assert property ($rose(arst_n_in) |=> xab_out == 2'h1)
      else $error("crystal mode not at default");
   a_soft_ready: assert property (soft_rst_out |=> !ready_out)
      else $error("ready high during soft reset");
   a_ready_drop: assert property ($fell(ready_out) |-> ##[0:2] soft_rst_out)
      else $error("ready fell without soft reset");
   c_soft: cover property ($rose(soft_rst_out));
   c_ready: cover property ($rose(ready_out));
   c_ack: cover property ($rose(sda_oe_out) ##1 sda_oe_out);
endmodule : i2rb_bridge_assertions
bind i2rb_bridge i2rb_bridge_assertions u_i2rb_bridge_assertions (
   .core_clk_in(core_clk_in), .arst_n_in(arst_n_in), .scl_in(scl_in),
   .sda_out(sda_out), .sda_oe_out(sda_oe_out), .ready_out(ready_out),
   .soft_rst_out(soft_rst_out), .xab_out(xab_out));

// ---- i2rb_master.sv ----
/* Behavioural two-wire bus master: drives the clock, pulls data low.
 Assumes a pull-up on the data wire outside; samples the resolved level. */
`timescale 1ns/10ps
module i2rb_master (
   input  wire logic core_clk_in,
   input  wire logic sda_in,
   output logic      scl_out,
   output logic      sda_low_out
);
   initial begin
      scl_out = 1'b1;
      sda_low_out = 1'b0;
   end
   task automatic hw;  // a third of a bit, well above the pin filter delay
      repeat (16) @(negedge core_clk_in);
   endtask : hw
   task automatic bit_io(input logic b, output logic got);
      scl_out = 1'b0;
      hw();
      sda_low_out = !b;  // data moves only while clock is low
      hw();
      scl_out = 1'b1;
      hw();
      got = sda_in;
   endtask : bit_io
   task automatic start;  // from idle or mid-frame as repeated start
      logic d;
      bit_io(1'b1, d);
      sda_low_out = 1'b1;
      hw();
   endtask : start
   task automatic stop;  // ends every frame
      logic d;
      bit_io(1'b0, d);
      sda_low_out = 1'b0;
      hw();
   endtask : stop
   task automatic xfer(input logic [7:0] tx, input logic ack_in,
                       output logic [7:0] rx, output logic ack);
      for (int i = 7; i >= 0; i--) bit_io(tx[i], rx[i]);  // msb first
      bit_io(ack_in, ack);
   endtask : xfer
endmodule : i2rb_master

// ---- test_i2rb_bridge.sv ----
/* Self-checking bench for the two-wire register bridge.
 Assumes the master model owns the bus clock and its share of data. */
`timescale 1ns/10ps
module test_i2rb_bridge;
   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic [1:0]  sel = 2'h0;
   logic        ifp = 1'b1;
   logic [7:0]  lvl = 8'h00;
   logic        scl, m_low, sda, oe, sdo, rdy, srst;
   logic [1:0]  xab;
   logic [6:0]  dev;
   logic [7:0]  q[4];
   logic [8:0]  a;
   logic [16:0] rnd = 17'h174ba;
   int          bad_count = 0;
   int          n_tests = 0;
   assign sda = !(m_low || (oe && !sdo));  // pulled-up wire
   assign dev = sel == 2'h0 ? i2rb_pkg::SLAVE_ADDR0 :
                sel == 2'h1 ? i2rb_pkg::SLAVE_ADDR1 : i2rb_pkg::SLAVE_ADDR2;
   initial forever #10 clk = !clk;
   i2rb_bridge #(.READY_CYCLES(20)) u_i2rb_bridge (.core_clk_in(clk),
      .arst_n_in(rst_n), .scl_in(scl), .sda_in(sda), .addr_sel_in(sel),
      .iface_select_pin_one_in(ifp), .status_level_in(lvl), .sda_out(sdo),
      .sda_oe_out(oe), .ready_out(rdy), .soft_rst_out(srst), .xab_out(xab));
   i2rb_master u_i2rb_master (.core_clk_in(clk), .sda_in(sda),
      .scl_out(scl), .sda_low_out(m_low));
   function automatic logic [16:0] step(input logic [16:0] s);
      return {s[15:0], s[16] ^ s[13]};
   endfunction : step
   task automatic test_done;
      $display("checks %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : test_done
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      n_tests++;
      if (g !== e) begin
         bad_count++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic wait_for(input int w, input logic v);
      for (int i = 0; i < 300 && (w ? srst : rdy) !== v; i++) @(negedge clk);
      chk(w ? "soft reset" : "ready", {7'h0, v}, {7'h0, w ? srst : rdy});
      if ((w ? srst : rdy) !== v) test_done();
   endtask : wait_for
   task automatic put(input logic [7:0] b, input logic exp_ack);
      logic [7:0] rx;
      logic       ak;
      u_i2rb_master.xfer(b, 1'b1, rx, ak);
      chk("ack", {7'h0, !exp_ack}, {7'h0, ak});
   endtask : put
   task automatic setup(input logic [7:0] c, input logic [8:0] ad);
      u_i2rb_master.start();
      put({dev, 1'b0}, 1'b1);  // own address
      put(c, 1'b1);  // command code
      put({7'h0, ad[8]}, 1'b1);
      put(ad[7:0], 1'b1);
   endtask : setup
   task automatic wr(input logic [8:0] ad, input int n);
      setup(i2rb_pkg::CMD_WR, ad);
      for (int i = 0; i < n; i++) put(q[i], 1'b1);
      u_i2rb_master.stop();
   endtask : wr
   task automatic other_slave;
      u_i2rb_master.start();
      put(8'ha6, 1'b0);  // foreign address left alone
      u_i2rb_master.stop();
   endtask : other_slave
   task automatic rd(input logic [8:0] ad, input int n, input logic ps,
                     input logic stale);
      logic [7:0] rx;
      logic       ak;
      setup(i2rb_pkg::CMD_RD, ad);
      if (ps) u_i2rb_master.stop();
      if (stale) other_slave();
      u_i2rb_master.start();  // stop-start or repeated start
      put({dev, 1'b1}, 1'b1);
      for (int i = 0; i < n; i++) begin
         u_i2rb_master.xfer(8'hff, i == n - 1, rx, ak);
         chk("read", q[stale ? 0 : i], rx);
      end
      u_i2rb_master.stop();
   endtask : rd
   initial begin
      for (int k = 0; k < 3; k++) begin
         sel = k[1:0];
         rst_n = 1'b0;
         repeat (k == 0 ? 5 : 50) @(negedge clk);  // 1 us once running
         chk("oe in reset", 8'h00, {7'h0, oe});
         rst_n = 1'b1;  // one rising edge per reset
         @(negedge clk);
         chk("xab", 8'h01, {6'h0, xab});
         wait_for(0, 1'b1);
         rnd = step(rnd);
         a = k == 0 ? 9'h1fc : {1'b1, rnd[7:0] & 8'hef};  // top edge first
         for (int i = 0; i < 4; i++) begin
            rnd = step(rnd);
            q[i] = rnd[7:0];
         end
         wr(a, 4);
         rd(a, 4, k[0], 1'b0);
         rd(a, 3, 1'b1, 1'b1);
         other_slave();
      end
      ifp = 1'b0;  // strap moves after capture
      q[0] = 8'h82;
      wr(i2rb_pkg::MCR_ADDR, 1);
      wait_for(1, 1'b1);
      chk("xab", 8'h01, {6'h0, xab});  // held at default
      q[0] = 8'h00;
      rd(a, 1, 1'b0, 1'b0);
      q[0] = 8'h02;
      wr(i2rb_pkg::MCR_ADDR, 1);
      wait_for(1, 1'b0);
      chk("xab", 8'h02, {6'h0, xab});  // read-write field
      wait_for(0, 1'b1);
      q[0] = {5'h00, 1'b1, sel};
      rd(i2rb_pkg::STRAP_ADDR, 1, 1'b0, 1'b0);  // straps kept
      q[0] = 8'h00;
      wr(i2rb_pkg::GSTAT_ADDR, 1);
      q[0] = 8'h80;
      rd(i2rb_pkg::GSTAT_ADDR, 1, 1'b0, 1'b0);
      rnd = step(rnd);
      lvl = rnd[7:0] | 8'h01;
      q[0] = lvl;
      rd(i2rb_pkg::RT_ADDR, 1, 1'b0, 1'b0);
      for (int j = 0; j < 2; j++) begin
         q[0] = j == 0 ? 8'h00 : 8'hff;
         wr(i2rb_pkg::LATCH_ADDR, 1);
         q[0] = j == 0 ? lvl : 8'h00;
         rd(i2rb_pkg::LATCH_ADDR, 1, 1'b0, 1'b0);
      end
      test_done();
   end
endmodule : test_i2rb_bridge
